// ---- design/jtag_tap.sv ----
// test access port with instruction, bypass, identification and boundary chains
`timescale 1ns/1ps
`default_nettype none
module jtag_tap
  import jtag_tap_pkg::*;
#(
  parameter int BSR_LEN = 8, // boundary chain length
  parameter logic [`ID_WIDTH-1:0] ID_VALUE = `ID_DEFAULT // arbitrary value
)
(
  input wire logic clock,
  input wire logic rst_n, // power-on reset
  input wire logic trst_n, // test reset pin
  input wire logic tck, // test clock pin
  input wire logic tms, // mode select pin
  input wire logic tdi, // serial data in pin
  output logic tdo, // serial data out pin
  output logic tdo_oe, // high while tdo is driven
  input wire logic core_tdo, // serial out of the core debug port, same clock
  output logic core_select, // core debug instruction held
  input wire logic [BSR_LEN-1:0] bsr_capture_data, // pin states to sample
  output logic [BSR_LEN-1:0] bsr_update_data, // preloaded pin values
  output logic ext_test_active, // hold pins from preloaded values
  output logic int_test_active, // drive core from preloaded values
  output logic [`IR_WIDTH-1:0] current_instr, // held instruction
  output jtag_tap_pkg::tap_state_t tap_state
);

  // chain select for a held instruction
  function automatic chain_sel_t decode_chain(input logic [`IR_WIDTH-1:0] code);
    chain_sel_t sel;
    case (code)
      `INSTR_IDENT: sel = CHAIN_IDENT;
      `INSTR_SAMPLE: sel = CHAIN_BOUNDARY;
      `INSTR_EXTEST: sel = CHAIN_FROZEN;
      `INSTR_INTEST: sel = CHAIN_FROZEN;
      `INSTR_ABORT: sel = CHAIN_CORE;
      `INSTR_DEBUG_PORT: sel = CHAIN_CORE;
      `INSTR_ACCESS_PORT: sel = CHAIN_CORE;
      default: sel = CHAIN_BYPASS;
    endcase
    return sel;
  endfunction

  // test reset pin: asserts at once, releases through two flops
  logic trst_meta;
  logic trst_sync;
  // pin synchronisers, first stage read only by the second
  logic tck_meta;
  logic tck_sync;
  logic tck_prev;
  logic tms_meta;
  logic tms_sync;
  logic tdi_meta;
  logic tdi_sync;
  // chains
  logic [`IR_WIDTH-1:0] ir_shift;
  logic [`IR_WIDTH-1:0] ir_hold;
  logic bypass_bit;
  logic [`ID_WIDTH-1:0] id_shift;
  logic [BSR_LEN-1:0] bsr_shift;

  wire tap_rst_n;
  wire tck_rise;
  wire tck_fall;
  wire chain_sel_t chain;
  wire in_shift_ir;
  wire in_shift_dr;
  wire dr_capture;
  wire dr_shift;
  wire dr_update;
  wire dr_lsb;
  wire next_tdo;
  wire next_tdo_oe;

  // combined reset: either source forces the reset state asynchronously
  assign tap_rst_n = rst_n & trst_sync;

  // release of test reset synchronised to the sampling clock
  always_ff @(posedge clock or negedge trst_n)
  begin
    if (!trst_n)
    begin
      trst_meta <= 1'b0;
      trst_sync <= 1'b0;
    end
    else
    begin
      trst_meta <= 1'b1;
      trst_sync <= trst_meta;
    end
  end

  // two-flop sampling of the test pins; tck, tms, tdi keep the same delay
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tck_meta <= 1'b0;
      tck_sync <= 1'b0;
      tck_prev <= 1'b0;
      tms_meta <= 1'b1;
      tms_sync <= 1'b1;
      tdi_meta <= 1'b1;
      tdi_sync <= 1'b1;
    end
    else
    begin
      tck_meta <= tck;
      tck_sync <= tck_meta;
      tck_prev <= tck_sync;
      tms_meta <= tms;
      tms_sync <= tms_meta;
      tdi_meta <= tdi;
      tdi_sync <= tdi_meta;
    end
  end

  // edges of the test clock; none while it stands still
  assign tck_rise = tck_sync & ~tck_prev;
  assign tck_fall = ~tck_sync & tck_prev;

  tap_state_machine u_fsm (
    .clock(clock),
    .tap_rst_n(tap_rst_n),
    .step(tck_rise),
    .tms(tms_sync),
    .state(tap_state)
  );

  // state decides instruction or data side and the operation timing
  assign chain = decode_chain(ir_hold);
  assign in_shift_ir = (tap_state == SHIFT_IR);
  assign in_shift_dr = (tap_state == SHIFT_DR);
  // frozen instructions never capture, shift or update a data chain
  assign dr_capture = tck_rise && tap_state == CAPTURE_DR && chain != CHAIN_FROZEN;
  assign dr_shift = tck_rise && in_shift_dr && chain != CHAIN_FROZEN;
  assign dr_update = tck_rise && tap_state == UPDATE_DR && chain != CHAIN_FROZEN;

  // instruction chain and held instruction
  always_ff @(posedge clock or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
    begin
      ir_shift <= `IR_CAPTURE_VALUE;
      ir_hold <= `INSTR_IDENT;
    end
    else if (tap_state == TEST_LOGIC_RESET)
    begin
      // holding here reloads the default on every cycle, so every entry does
      ir_hold <= `INSTR_IDENT;
    end
    else if (tck_rise)
    begin
      if (tap_state == CAPTURE_IR)
        ir_shift <= `IR_CAPTURE_VALUE;
      else if (in_shift_ir)
        ir_shift <= {tdi_sync, ir_shift[`IR_WIDTH-1:1]};
      else if (tap_state == UPDATE_IR)
        ir_hold <= ir_shift;
    end
  end

  // bypass bit
  always_ff @(posedge clock or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      bypass_bit <= 1'b0;
    else if (chain == CHAIN_BYPASS)
    begin
      if (dr_capture)
        bypass_bit <= 1'b0;
      else if (dr_shift)
        bypass_bit <= tdi_sync;
    end
  end

  // identification chain, reloaded on each capture
  always_ff @(posedge clock or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      id_shift <= '0;
    else if (chain == CHAIN_IDENT)
    begin
      if (dr_capture)
        id_shift <= ID_VALUE;
      else if (dr_shift)
        id_shift <= {tdi_sync, id_shift[`ID_WIDTH-1:1]};
    end
  end

  // boundary chain; its parallel register survives test reset for the pins
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bsr_shift <= '0;
      bsr_update_data <= '0;
    end
    else if (chain == CHAIN_BOUNDARY)
    begin
      if (dr_capture)
        bsr_shift <= bsr_capture_data;
      else if (dr_shift)
        bsr_shift <= {tdi_sync, bsr_shift[BSR_LEN-1:1]};
      else if (dr_update)
        bsr_update_data <= bsr_shift;
    end
  end

  // serial out selection; core instructions route the core port out
  assign dr_lsb = (chain == CHAIN_IDENT) ? id_shift[0] :
                  (chain == CHAIN_BOUNDARY) ? bsr_shift[0] :
                  (chain == CHAIN_CORE) ? core_tdo : bypass_bit;
  assign next_tdo = in_shift_ir ? ir_shift[0] : dr_lsb;
  // driven only while a shift is in progress; frozen chains do not shift
  assign next_tdo_oe = in_shift_ir || (in_shift_dr && chain != CHAIN_FROZEN);

  // output changes only on a seen falling edge of the test clock
  always_ff @(posedge clock or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
    begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo <= next_tdo;
      tdo_oe <= next_tdo_oe;
    end
  end

  // status levels for the rest of the device
  assign core_select = (chain == CHAIN_CORE);
  assign ext_test_active = (ir_hold == `INSTR_EXTEST);
  assign int_test_active = (ir_hold == `INSTR_INTEST);
  assign current_instr = ir_hold;
endmodule
`default_nettype wire

// ---- design/jtag_tap_params.svh ----
// constants for the test access port: instruction codes, widths, reset values
`ifndef JTAG_TAP_PARAMS_SVH
`define JTAG_TAP_PARAMS_SVH

`define IR_WIDTH 4
`define ID_WIDTH 32
// instruction codes
`define INSTR_EXTEST 4'h0
`define INSTR_INTEST 4'h1
`define INSTR_SAMPLE 4'h2
`define INSTR_ABORT 4'h8
`define INSTR_DEBUG_PORT 4'hA
`define INSTR_ACCESS_PORT 4'hB
`define INSTR_IDENT 4'hE
`define INSTR_BYPASS 4'hF
// value loaded into the instruction chain in capture
`define IR_CAPTURE_VALUE 4'h1
// identification word, arbitrary value
`define ID_DEFAULT 32'h0000_1001

`endif

// ---- design/jtag_tap_pkg.sv ----
// types shared by the test access port modules
`include "jtag_tap_params.svh"
package jtag_tap_pkg;
  typedef enum logic [3:0] {
    TEST_LOGIC_RESET = 4'b1111,
    RUN_TEST_IDLE = 4'b1100,
    SELECT_DR = 4'b0111,
    CAPTURE_DR = 4'b0110,
    SHIFT_DR = 4'b0010,
    EXIT1_DR = 4'b0001,
    PAUSE_DR = 4'b0011,
    EXIT2_DR = 4'b0000,
    UPDATE_DR = 4'b0101,
    SELECT_IR = 4'b0100,
    CAPTURE_IR = 4'b1110,
    SHIFT_IR = 4'b1010,
    EXIT1_IR = 4'b1001,
    PAUSE_IR = 4'b1011,
    EXIT2_IR = 4'b1000,
    UPDATE_IR = 4'b1101
  } tap_state_t;

  // which data chain the held instruction routes to
  typedef enum logic [2:0] {
    CHAIN_BYPASS = 3'b000,
    CHAIN_IDENT = 3'b001,
    CHAIN_BOUNDARY = 3'b010,
    CHAIN_CORE = 3'b011,
    CHAIN_FROZEN = 3'b100
  } chain_sel_t;
endpackage

// ---- design/tap_state_machine.sv ----
// sixteen-state test access port controller
`timescale 1ns/1ps
`default_nettype none
module tap_state_machine
  import jtag_tap_pkg::*;
(
  input wire logic clock,
  input wire logic tap_rst_n, // power-on and test reset combined
  input wire logic step, // one-cycle pulse on a test clock rise
  input wire logic tms,
  output jtag_tap_pkg::tap_state_t state
);
  tap_state_t next_state;

  // next state from current state and sampled mode bit
  always_comb
  begin
    next_state = state;
    unique case (state)
      TEST_LOGIC_RESET: next_state = tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
      RUN_TEST_IDLE: next_state = tms ? SELECT_DR : RUN_TEST_IDLE;
      SELECT_DR: next_state = tms ? SELECT_IR : CAPTURE_DR;
      CAPTURE_DR: next_state = tms ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR: next_state = tms ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR: next_state = tms ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR: next_state = tms ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR: next_state = tms ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR: next_state = tms ? SELECT_DR : RUN_TEST_IDLE;
      SELECT_IR: next_state = tms ? TEST_LOGIC_RESET : CAPTURE_IR;
      CAPTURE_IR: next_state = tms ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR: next_state = tms ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR: next_state = tms ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR: next_state = tms ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR: next_state = tms ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR: next_state = tms ? SELECT_DR : RUN_TEST_IDLE;
    endcase
  end

  // state moves only on a seen test clock rise
  always_ff @(posedge clock or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      state <= TEST_LOGIC_RESET;
    else if (step)
      state <= next_state;
  end
endmodule
`default_nettype wire

// ---- tb/jtag_debugger.sv ----
// model of the external debugger driving the test pins
`timescale 1ns/1ps
`default_nettype none
module jtag_debugger
(
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // pins rest at pulled-up levels, clock parked low between frames
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one test clock period; pins move just after the fall
  task automatic pulse(input logic m, input logic d, output logic o, output logic oe);
    tms = m;
    tdi = d;
    #62.5;
    o = tdo;
    oe = tdo_oe;
    tck = 1'b1;
    #62.5;
    tck = 1'b0;
  endtask
  // serial-wire switch word framed by high clocks on the mode line
  task automatic switch_seq(input logic [15:0] word, input int tail);
    logic o;
    logic oe;
    repeat (50) pulse(1'b1, 1'b1, o, oe);
    for (int i = 0; i < 16; i++)
      pulse(word[i], 1'b1, o, oe);
    repeat (tail) pulse(1'b1, 1'b1, o, oe);
  endtask
  // idle to capture, n shifts lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output logic oe_all);
    logic o;
    logic oe;
    dout = '0;
    oe_all = 1'b1;
    pulse(1'b1, 1'b1, o, oe);
    if (ir)
      pulse(1'b1, 1'b1, o, oe);
    pulse(1'b0, 1'b1, o, oe);
    pulse(1'b0, 1'b1, o, oe);
    for (int i = 0; i < n; i++)
    begin
      pulse(i == n - 1, din[i], o, oe);
      dout[i] = o;
      oe_all &= oe;
    end
    pulse(1'b1, 1'b1, o, oe);
    pulse(1'b0, 1'b1, o, oe);
  endtask
endmodule
`default_nettype wire

// ---- tb/jtag_tap_and_scan_chains_test.sv ----
// self-checking bench for the test access port
`timescale 1ns/1ps
`default_nettype none
`include "jtag_tap_params.svh"
module jtag_tap_and_scan_chains_test;
  import jtag_tap_pkg::*;
  localparam int BSR_LEN = 8;
  logic clock, rst_n, trst_n, core_tdo, tck, tms, tdi, tdo, tdo_oe, o, oe;
  logic core_select, ext_test_active, int_test_active;
  logic [BSR_LEN-1:0] bsr_capture_data, bsr_update_data, prev;
  logic [3:0] current_instr;
  tap_state_t tap_state;
  int mismatches = 0, num_checks = 0;
  logic [7:0] seed = 8'h56;
  logic [31:0] dout, rnd;
  // sample first so the later freeze check sees a nonzero preload
  logic [3:0] codes [10] = '{4'h2, 4'h0, 4'h1, 4'h8, 4'hA, 4'hB, 4'hE, 4'hF, 4'h3, 4'hC};
  jtag_tap #(.BSR_LEN(BSR_LEN)) i_jtag_tap (.clock(clock), .rst_n(rst_n), .trst_n(trst_n),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .core_tdo(core_tdo),
    .core_select(core_select), .bsr_capture_data(bsr_capture_data),
    .bsr_update_data(bsr_update_data), .ext_test_active(ext_test_active),
    .int_test_active(int_test_active), .current_instr(current_instr), .tap_state(tap_state));
  jtag_debugger i_jtag_debugger (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // expected 8-bit data scan out; core path repeats the core's level
  function automatic logic [7:0] exp_dr(input logic [3:0] c, input logic [7:0] d);
    case (c)
      `INSTR_SAMPLE: return bsr_capture_data;
      `INSTR_IDENT: return 8'(`ID_DEFAULT);
      `INSTR_ABORT, `INSTR_DEBUG_PORT, `INSTR_ACCESS_PORT: return {8{core_tdo}};
      default: return {d[6:0], 1'b0};
    endcase
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // watchdog, well past the expected run of about 64 us
  initial
  begin
    #200us;
    mismatches++;
    finish_test();
  end
  task in_reset;
    check(32'(tap_state), 32'(TEST_LOGIC_RESET));
    check(32'(current_instr), 32'(`INSTR_IDENT));
  endtask
  initial
  begin
    {rst_n, trst_n, bsr_capture_data} = '0;
    core_tdo = 1'b1;
    repeat (2) @(negedge clock);
    {rst_n, trst_n} = 2'b11;
    repeat (4) @(negedge clock);
    in_reset();
    i_jtag_debugger.pulse(1'b0, 1'b1, o, oe);
    i_jtag_debugger.scan(1'b0, 32, 32'h0, dout, oe);
    check(dout, `ID_DEFAULT);
    check(32'(oe), 32'h1);
    check(32'(tdo_oe), 32'h0);
    foreach (codes[k])
    begin
      seed = lfsr(seed);
      @(negedge clock) {core_tdo, bsr_capture_data} = {seed[3], seed};
      i_jtag_debugger.scan(1'b1, 4, 32'(codes[k]), dout, oe);
      check(32'(dout[3:0]), 32'(`IR_CAPTURE_VALUE));
      check(32'(current_instr), 32'(codes[k]));
      seed = lfsr(seed);
      rnd = 32'(seed);
      prev = bsr_update_data;
      i_jtag_debugger.scan(1'b0, 8, rnd, dout, oe);
      if (codes[k] < 4'h2)
      begin
        check(32'(oe), 32'h0);
        check(32'(bsr_update_data), 32'(prev));
      end
      else
        check(32'(dout[7:0]), 32'(exp_dr(codes[k], rnd[7:0])));
      if (codes[k] == `INSTR_SAMPLE)
        check(32'(bsr_update_data), rnd);
    end
    repeat (5) i_jtag_debugger.pulse(1'b1, 1'b1, o, oe);
    in_reset();
    // switch words only walk the port through legal states; the tail ends in reset
    i_jtag_debugger.switch_seq(16'hE79E, 50);
    i_jtag_debugger.switch_seq(16'hE73C, 5);
    in_reset();
    i_jtag_debugger.pulse(1'b0, 1'b1, o, oe);
    repeat (300) @(negedge clock);
    check(32'(tap_state), 32'(RUN_TEST_IDLE));
    i_jtag_debugger.scan(1'b1, 4, 32'h2, dout, oe);
    trst_n = 1'b0;
    repeat (3) @(negedge clock);
    in_reset();
    trst_n = 1'b1;
    repeat (4) @(negedge clock);
    i_jtag_debugger.pulse(1'b0, 1'b1, o, oe);
    i_jtag_debugger.scan(1'b1, 4, 32'h2, dout, oe);
    i_jtag_debugger.scan(1'b0, 8, 32'hA5, dout, oe);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    in_reset();
    check(32'(bsr_update_data), 32'h0);
    rst_n = 1'b1;
    finish_test();
  end
endmodule
bind jtag_tap jtag_tap_monitor #(.BSR_LEN(BSR_LEN)) i_jtag_tap_monitor (.clock(clock),
  .rst_n(rst_n), .trst_n(trst_n), .tck(tck), .tms(tms), .tdo(tdo), .tdo_oe(tdo_oe),
  .core_select(core_select), .bsr_update_data(bsr_update_data),
  .ext_test_active(ext_test_active), .int_test_active(int_test_active),
  .current_instr(current_instr), .tap_state(tap_state));
`default_nettype wire

// ---- tb/jtag_tap_monitor.sv ----
// assertion checker for the test access port
`timescale 1ns/1ps
`default_nettype none
`include "jtag_tap_params.svh"
module jtag_tap_monitor
  import jtag_tap_pkg::*;
#(
  parameter int BSR_LEN = 8
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic trst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic core_select,
  input wire logic [BSR_LEN-1:0] bsr_update_data,
  input wire logic ext_test_active,
  input wire logic int_test_active,
  input wire logic [`IR_WIDTH-1:0] current_instr,
  input wire jtag_tap_pkg::tap_state_t tap_state
);
  logic t1, t2; // test clock seen through two flops
  logic [3:0] quiet; // clocks since the test clock last moved or test reset was low
  logic [2:0] ones; // rises in a row with mode high, saturates at five
  wire rise = t1 & ~t2;
  wire moved = t1 ^ t2;
  // edge history; counts saturate so long idles cannot wrap
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {t1, t2, quiet, ones} <= '0;
    end
    else
    begin
      t2 <= t1;
      t1 <= tck;
      quiet <= (moved || !trst_n) ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
      if (rise)
        ones <= tms ? ones + {2'h0, ones != 3'h5} : 3'h0;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_trst_holds_reset:
    assert property (!trst_n |=> tap_state == TEST_LOGIC_RESET)
    else $error("test reset did not hold reset state");
  a_por_enters_reset:
    assert property ($rose(rst_n) |-> tap_state == TEST_LOGIC_RESET)
    else $error("power-on reset left port out of reset state");
  a_reset_loads_ident:
    assert property (tap_state == TEST_LOGIC_RESET |=> current_instr == `INSTR_IDENT)
    else $error("reset state did not load ident instruction");
  a_five_high_reset:
    assert property ($rose(ones == 3'h5) |-> ##[0:6] tap_state == TEST_LOGIC_RESET)
    else $error("five high mode rises did not reach reset state");
  a_static_tck_hold:
    assert property (quiet > 4'h7 |-> $stable(tap_state) && $stable(current_instr)
      && $stable(bsr_update_data))
    else $error("state moved without test clock");
  // test reset clears the output at once, whatever the clock phase
  a_out_after_fall:
    assert property (trst_n && ($changed(tdo) || $changed(tdo_oe))
      |-> !tck && !$past(tck, 2))
    else $error("serial out changed outside low clock phase");
  a_oe_only_shift:
    assert property ($rose(tdo_oe) |-> tap_state inside {SHIFT_IR, SHIFT_DR})
    else $error("serial out driven outside shift");
  a_core_mux_select:
    assert property (core_select == (current_instr inside
      {`INSTR_ABORT, `INSTR_DEBUG_PORT, `INSTR_ACCESS_PORT}))
    else $error("core select wrong for held instruction");
  a_frozen_flags:
    assert property (ext_test_active == (current_instr == `INSTR_EXTEST)
      && int_test_active == (current_instr == `INSTR_INTEST))
    else $error("test mode flags wrong");
endmodule
`default_nettype wire
